// file: hdl/bcc_regs.svh
// Register offsets, field positions, reset values and timing for the clock/calendar
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BCC_ADDR_SEC 4'h0
`define BCC_ADDR_MIN 4'h1
`define BCC_ADDR_HOUR 4'h2
`define BCC_ADDR_WDAY 4'h3
`define BCC_ADDR_MDAY 4'h4
`define BCC_ADDR_MON 4'h5
`define BCC_ADDR_YEAR 4'h6
`define BCC_ADDR_ALM_FIRST 4'h7
`define BCC_ADDR_ALM_LAST 4'hD
`define BCC_ADDR_CTRL 4'hE
`define BCC_ADDR_STAT 4'hF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BCC_HR_FMT 6
`define BCC_HR_PM 5
`define BCC_MON_CENT 7
`define BCC_ALM_MASK 7
`define BCC_ALM_DAYSEL 6
`define BCC_STAT_OSF 7
`define BCC_STAT_A2F 1
`define BCC_STAT_A1F 0

// ----------------------------------------
// Reset values, write masks, limits
// ----------------------------------------
`define BCC_ZERO_RST 8'h00
`define BCC_ONE_RST 8'h01
`define BCC_CTRL_RST 8'h18
`define BCC_SEC_WMASK 8'h7F
`define BCC_HR_WMASK 8'h7F
`define BCC_WDAY_WMASK 8'h07
`define BCC_MDAY_WMASK 8'h3F
`define BCC_MON_WMASK 8'h9F
`define BCC_CTRL_WMASK 8'h9F
`define BCC_SEC_MAX 8'h59
`define BCC_WDAY_MAX 8'h07
`define BCC_MON_MAX 8'h12
`define BCC_YEAR_MAX 8'h99

// ----------------------------------------
// Timing
// ----------------------------------------
`define BCC_CLK_PERIOD_NS 4
`define BCC_OSC_TIMEOUT_NS 100000
`define BCC_XTAL_HZ 32768

`endif

// file: hdl/bcc_pkg.sv
// Types shared by the clock/calendar design
package bcc_pkg;

    typedef struct packed {
        logic ptrLoad;
        logic wrStb;
        logic rdStb;
        logic [7:0] data;
    } bcc_host_req_t;

    typedef enum logic [1:0] {
        RATE_1HZ = 2'b00,
        RATE_4K = 2'b01,
        RATE_8K = 2'b10,
        RATE_32K = 2'b11
    } bcc_rate_t;

    typedef struct packed {
        logic crystalDisable;
        logic [1:0] unused;
        bcc_rate_t clockoutRate;
        logic pinRouteSelect;
        logic secondAlarmIrqEn;
        logic firstAlarmIrqEn;
    } bcc_ctrl_t;

endpackage

// file: hdl/bcc_pin_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/1ps
module bcc_pin_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pinIn,
    output logic level
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Change accepted only once the last two stages agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= 1'b0;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end
endmodule

// file: hdl/bcc_bcd_step.sv
// One BCD field advanced by one, wrapping from a limit to a start value
`timescale 1ns/1ps
module bcc_bcd_step (
    input wire logic [7:0] cur,
    input wire logic [7:0] maxVal,
    input wire logic [7:0] minVal,
    output logic [7:0] next,
    output logic wrap
);
    always_comb begin
        wrap = (cur == maxVal);
        if (wrap) begin
            next = minVal;
        end else if (cur[3:0] >= 4'h9) begin
            next = {cur[7:4] + 4'h1, 4'h0};
        end else begin
            next = cur + 8'h01;
        end
    end
endmodule

// file: hdl/bcc_clock_calendar.sv
// Clock/calendar core: BCD time counters, two alarms, pin routing, register port
`timescale 1ns/1ps
`include "bcc_regs.svh"

module bcc_clock_calendar #(
    parameter int XTAL_DIV = `BCC_XTAL_HZ,
    parameter int OSC_TIMEOUT_CYC = `BCC_OSC_TIMEOUT_NS / `BCC_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic crystalInputPin,
    input wire bcc_pkg::bcc_host_req_t hostReq,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic irqOrClockoutPin,
    output logic secondIrqPinN
);
    localparam int PW = $clog2(XTAL_DIV);
    localparam int WW = $clog2(OSC_TIMEOUT_CYC + 1);
    localparam logic [PW-1:0] PRESCALE_TOP = PW'(XTAL_DIV - 1);
    localparam logic [WW-1:0] WATCH_TOP = WW'(OSC_TIMEOUT_CYC);

    logic [3:0] regPtr;
    logic [7:0] secCnt, minCnt, hrCnt, wdayCnt, mdayCnt, monCnt, yearCnt;
    logic [7:0] alarmReg [7];
    bcc_pkg::bcc_ctrl_t ctrl;
    logic crystal_fail_flag, a2f, a1f;
    logic xtalLevel, xtalPrev, xtalEdge;
    logic [PW-1:0] prescale;
    logic [WW-1:0] watchdog;
    logic oscFail, secTick, evalTick;
    logic hostWr, hostRd, timeWr, statWr;
    logic [7:0] fieldCur [6];
    logic [7:0] fieldMax [6];
    logic [7:0] fieldMin [6];
    logic [7:0] fieldNext [6];
    logic fieldWrap [6];
    logic [7:0] next_hr, daysInMonth, readMux;
    logic hrWrap, leapYear, minStep, hrStep, dayStep, monStep, yearStep;
    logic a1Set, a2Set, fout;

    // ----------------------------------------
    // Register port and pointer
    // ----------------------------------------
    assign hostWr = hostReq.wrStb & ~hostReq.ptrLoad;
    assign hostRd = hostReq.rdStb & ~hostReq.ptrLoad & ~hostReq.wrStb;
    assign timeWr = hostWr & (regPtr <= `BCC_ADDR_YEAR);
    assign statWr = hostWr & (regPtr == `BCC_ADDR_STAT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regPtr <= `BCC_ADDR_SEC;
        end else if (hostReq.ptrLoad) begin
            regPtr <= hostReq.data[3:0];
        end else if (hostWr | hostRd) begin
            regPtr <= regPtr + 4'h1; // Four bits, so 0Fh rolls to 00h
        end
    end

    always_comb begin
        case (regPtr)
            `BCC_ADDR_SEC: readMux = secCnt;
            `BCC_ADDR_MIN: readMux = minCnt;
            `BCC_ADDR_HOUR: readMux = hrCnt;
            `BCC_ADDR_WDAY: readMux = wdayCnt;
            `BCC_ADDR_MDAY: readMux = mdayCnt;
            `BCC_ADDR_MON: readMux = monCnt;
            `BCC_ADDR_YEAR: readMux = yearCnt;
            `BCC_ADDR_CTRL: readMux = ctrl;
            `BCC_ADDR_STAT: readMux = {crystal_fail_flag, 5'h00, a2f, a1f};
            default: readMux = alarmReg[3'(regPtr - `BCC_ADDR_ALM_FIRST)];
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData <= `BCC_ZERO_RST;
            rdValid <= 1'b0;
        end else begin
            rdValid <= hostRd;
            if (hostRd) begin
                rdData <= readMux;
            end
        end
    end

    // ----------------------------------------
    // Crystal time base and failure watch
    // ----------------------------------------
    bcc_pin_sync xtalSync (
        .clk(clk),
        .rst(rst),
        .pinIn(crystalInputPin),
        .level(xtalLevel)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xtalPrev <= 1'b0;
        end else begin
            xtalPrev <= xtalLevel;
        end
    end

    // Disabled oscillator: edges are ignored, so time stops and fail shows
    assign xtalEdge = xtalLevel & ~xtalPrev & ~ctrl.crystalDisable;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdog <= '0;
        end else if (xtalEdge) begin
            watchdog <= '0;
        end else if (watchdog != WATCH_TOP) begin
            watchdog <= watchdog + 1'b1;
        end
    end
    assign oscFail = (watchdog == WATCH_TOP);

    // Time write restarts the divider so the 1 Hz output realigns
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prescale <= '0;
        end else if (timeWr) begin
            prescale <= '0;
        end else if (xtalEdge) begin
            prescale <= (prescale == PRESCALE_TOP) ? '0 : prescale + 1'b1;
        end
    end
    assign secTick = xtalEdge & (prescale == PRESCALE_TOP) & ~timeWr;

    // ----------------------------------------
    // Calendar step logic
    // ----------------------------------------
    always_comb begin
        leapYear = yearCnt[4] ? (yearCnt[3:0] == 4'h2 || yearCnt[3:0] == 4'h6)
                              : (yearCnt[3:0] == 4'h0 || yearCnt[3:0] == 4'h4 || yearCnt[3:0] == 4'h8);
        case (monCnt[4:0])
            5'h02: daysInMonth = leapYear ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: daysInMonth = 8'h30;
            default: daysInMonth = 8'h31;
        endcase
    end

    assign fieldCur[0] = secCnt;
    assign fieldCur[1] = minCnt;
    assign fieldCur[2] = wdayCnt;
    assign fieldCur[3] = mdayCnt;
    assign fieldCur[4] = {3'b000, monCnt[4:0]};
    assign fieldCur[5] = yearCnt;
    assign fieldMax[0] = `BCC_SEC_MAX;
    assign fieldMax[1] = `BCC_SEC_MAX;
    assign fieldMax[2] = `BCC_WDAY_MAX;
    assign fieldMax[3] = daysInMonth;
    assign fieldMax[4] = `BCC_MON_MAX;
    assign fieldMax[5] = `BCC_YEAR_MAX;
    assign fieldMin[0] = `BCC_ZERO_RST;
    assign fieldMin[1] = `BCC_ZERO_RST;
    assign fieldMin[2] = `BCC_ONE_RST;
    assign fieldMin[3] = `BCC_ONE_RST;
    assign fieldMin[4] = `BCC_ONE_RST;
    assign fieldMin[5] = `BCC_ZERO_RST;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : gStep
            bcc_bcd_step stepper (
                .cur(fieldCur[gi]),
                .maxVal(fieldMax[gi]),
                .minVal(fieldMin[gi]),
                .next(fieldNext[gi]),
                .wrap(fieldWrap[gi])
            );
        end
    endgenerate

    always_comb begin
        next_hr = hrCnt;
        hrWrap = 1'b0;
        if (hrCnt[`BCC_HR_FMT]) begin
            if (hrCnt[4:0] == 5'h12) begin
                next_hr[4:0] = 5'h01;
            end else if (hrCnt[4:0] == 5'h11) begin
                next_hr[4:0] = 5'h12;
                next_hr[`BCC_HR_PM] = ~hrCnt[`BCC_HR_PM];
                hrWrap = hrCnt[`BCC_HR_PM];
            end else if (hrCnt[3:0] >= 4'h9) begin
                next_hr[4:0] = 5'h10;
            end else begin
                next_hr[3:0] = hrCnt[3:0] + 4'h1;
            end
        end else begin
            if (hrCnt[5:0] == 6'h23) begin
                next_hr[5:0] = 6'h00;
                hrWrap = 1'b1;
            end else if (hrCnt[3:0] >= 4'h9) begin
                next_hr[5:0] = {hrCnt[5:4] + 2'h1, 4'h0};
            end else begin
                next_hr[3:0] = hrCnt[3:0] + 4'h1;
            end
        end
    end

    assign minStep = secTick & fieldWrap[0];
    assign hrStep = minStep & fieldWrap[1];
    assign dayStep = hrStep & hrWrap;
    assign monStep = dayStep & fieldWrap[3];
    assign yearStep = monStep & fieldWrap[4];

    // ----------------------------------------
    // Time registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            secCnt <= `BCC_ZERO_RST;
            minCnt <= `BCC_ZERO_RST;
            hrCnt <= `BCC_ZERO_RST; // 24-hour form
            wdayCnt <= `BCC_ONE_RST;
            mdayCnt <= `BCC_ONE_RST;
            monCnt <= `BCC_ONE_RST;
            yearCnt <= `BCC_ZERO_RST;
        end else if (timeWr) begin
            case (regPtr)
                `BCC_ADDR_SEC: secCnt <= hostReq.data & `BCC_SEC_WMASK;
                `BCC_ADDR_MIN: minCnt <= hostReq.data & `BCC_SEC_WMASK;
                `BCC_ADDR_HOUR: hrCnt <= hostReq.data & `BCC_HR_WMASK;
                `BCC_ADDR_WDAY: wdayCnt <= hostReq.data & `BCC_WDAY_WMASK;
                `BCC_ADDR_MDAY: mdayCnt <= hostReq.data & `BCC_MDAY_WMASK;
                `BCC_ADDR_MON: monCnt <= hostReq.data & `BCC_MON_WMASK;
                default: yearCnt <= hostReq.data;
            endcase
        end else if (secTick) begin
            secCnt <= fieldNext[0];
            if (minStep) begin
                minCnt <= fieldNext[1];
            end
            if (hrStep) begin
                hrCnt <= next_hr;
            end
            if (dayStep) begin
                wdayCnt <= fieldNext[2];
                mdayCnt <= fieldNext[3];
            end
            if (monStep) begin
                // Century flips only on the 99 to 00 roll, not on every new year
                monCnt <= {monCnt[`BCC_MON_CENT] ^ (yearStep & fieldWrap[5]), 2'b00, fieldNext[4][4:0]};
            end
            if (yearStep) begin
                yearCnt <= fieldNext[5];
            end
        end
    end

    // ----------------------------------------
    // Alarm and control registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 7; i++) begin
                alarmReg[i] <= `BCC_ZERO_RST;
            end
            ctrl <= bcc_pkg::bcc_ctrl_t'(`BCC_CTRL_RST); // Oscillator on
        end else if (hostWr) begin
            if (regPtr == `BCC_ADDR_CTRL) begin
                ctrl <= bcc_pkg::bcc_ctrl_t'(hostReq.data & `BCC_CTRL_WMASK);
            end else if (regPtr >= `BCC_ADDR_ALM_FIRST && regPtr <= `BCC_ADDR_ALM_LAST) begin
                alarmReg[3'(regPtr - `BCC_ADDR_ALM_FIRST)] <= hostReq.data;
            end
        end
    end

    // ----------------------------------------
    // Alarm comparison
    // ----------------------------------------
    function automatic logic dayHit(input logic [7:0] a, input logic [7:0] wd, input logic [7:0] md);
        if (a[`BCC_ALM_DAYSEL]) begin
            dayHit = (a[3:0] == wd[3:0]);
        end else begin
            dayHit = (a[5:0] == md[5:0]);
        end
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evalTick <= 1'b0;
        end else begin
            evalTick <= secTick; // Compare against the freshly updated time
        end
    end

    // Month and year are never consulted
    assign a1Set = evalTick
        & (alarmReg[0][`BCC_ALM_MASK] | (alarmReg[0][6:0] == secCnt[6:0]))
        & (alarmReg[1][`BCC_ALM_MASK] | (alarmReg[1][6:0] == minCnt[6:0]))
        & (alarmReg[2][`BCC_ALM_MASK] | (alarmReg[2][5:0] == hrCnt[5:0]))
        & (alarmReg[3][`BCC_ALM_MASK] | dayHit(alarmReg[3], wdayCnt, mdayCnt));
    assign a2Set = evalTick & (secCnt == `BCC_ZERO_RST)
        & (alarmReg[4][`BCC_ALM_MASK] | (alarmReg[4][6:0] == minCnt[6:0]))
        & (alarmReg[5][`BCC_ALM_MASK] | (alarmReg[5][5:0] == hrCnt[5:0]))
        & (alarmReg[6][`BCC_ALM_MASK] | dayHit(alarmReg[6], wdayCnt, mdayCnt));

    // ----------------------------------------
    // Status flags: a set in the clear cycle wins
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crystal_fail_flag <= 1'b1;
            a2f <= 1'b0;
            a1f <= 1'b0;
        end else begin
            a1f <= a1Set | (a1f & ~(statWr & ~hostReq.data[`BCC_STAT_A1F]));
            a2f <= a2Set | (a2f & ~(statWr & ~hostReq.data[`BCC_STAT_A2F]));
            crystal_fail_flag <= oscFail | (crystal_fail_flag & ~(statWr & ~hostReq.data[`BCC_STAT_OSF]));
        end
    end

    // ----------------------------------------
    // Pin routing
    // ----------------------------------------
    always_comb begin
        case (ctrl.clockoutRate)
            bcc_pkg::RATE_32K: fout = xtalLevel & ~ctrl.crystalDisable;
            bcc_pkg::RATE_8K: fout = prescale[1];
            bcc_pkg::RATE_4K: fout = prescale[2];
            default: fout = prescale[PW-1];
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqOrClockoutPin <= 1'b1;
            secondIrqPinN <= 1'b1;
        end else if (ctrl.pinRouteSelect) begin
            irqOrClockoutPin <= ~(a2f & ctrl.secondAlarmIrqEn);
            secondIrqPinN <= ~(a1f & ctrl.firstAlarmIrqEn);
        end else begin
            irqOrClockoutPin <= fout;
            secondIrqPinN <= ~((a1f & ctrl.firstAlarmIrqEn) | (a2f & ctrl.secondAlarmIrqEn));
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_ptr_wrap: assert property (@(posedge clk) disable iff (rst)
        (hostWr && regPtr == 4'hF) |=> regPtr == 4'h0) else $error("pointer did not wrap");
    chk_sec_rollover: assert property (@(posedge clk) disable iff (rst)
        (secTick && secCnt == 8'h59) |=> secCnt == 8'h00 && minCnt != $past(minCnt))
        else $error("seconds rollover wrong");
    chk_weekday_wrap: assert property (@(posedge clk) disable iff (rst)
        (dayStep && wdayCnt == 8'h07) |=> wdayCnt == 8'h01) else $error("weekday did not wrap to 1");
    chk_century_toggle: assert property (@(posedge clk) disable iff (rst)
        (yearStep && yearCnt == 8'h99) |=> yearCnt == 8'h00 && monCnt[7] != $past(monCnt[7]))
        else $error("century bit not toggled");
    chk_century_keep: assert property (@(posedge clk) disable iff (rst)
        (yearStep && yearCnt != 8'h99) |=> monCnt[7] == $past(monCnt[7])) else $error("century bit changed early");
    chk_a1_every_sec: assert property (@(posedge clk) disable iff (rst)
        (secTick && alarmReg[0][7] && alarmReg[1][7] && alarmReg[2][7] && alarmReg[3][7]) |=> ##1 a1f)
        else $error("first alarm missed a second");
    chk_a2_at_zero: assert property (@(posedge clk) disable iff (rst)
        $rose(a2f) |-> secCnt == 8'h00 && $past(evalTick)) else $error("second alarm off second zero");
    chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
        (statWr && !hostReq.data[0] && !a1Set) |=> !a1f) else $error("first alarm flag not cleared");
    chk_flag_noset: assert property (@(posedge clk) disable iff (rst)
        (!a1f && !a1Set) |=> !a1f) else $error("first alarm flag set by host");
    chk_osf_hold: assert property (@(posedge clk) disable iff (rst)
        oscFail |=> crystal_fail_flag) else $error("crystal fail flag not held");
    chk_route_irq: assert property (@(posedge clk) disable iff (rst)
        (ctrl.pinRouteSelect && a2f && ctrl.secondAlarmIrqEn) |=> !irqOrClockoutPin)
        else $error("shared pin not asserted");
    chk_route_fout: assert property (@(posedge clk) disable iff (rst)
        !ctrl.pinRouteSelect |=> irqOrClockoutPin == $past(fout)) else $error("clock output not routed");
endmodule

// file: verif/bcc_xtal_model.sv
// Crystal time-base model driving the core's crystal input
`timescale 1ns/1ps
module bcc_xtal_model #(
    parameter real HALF_NS = 48.0
) (
    input wire logic run,
    output logic pin
);
    // A stopped crystal holds its level, so no edges reach the core
    initial begin
        pin = 1'b0;
        #1.3;
        forever begin
            #(HALF_NS);
            if (run) begin
                pin = ~pin;
            end
        end
    end
endmodule

// file: verif/bcd_clock_calendar_alarms_test.sv
// Self-checking bench for the clock/calendar core
`timescale 1ns/1ps
module bcd_clock_calendar_alarms_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic xtalRun = 1'b1;
    logic xtalPin;
    bcc_pkg::bcc_host_req_t hostReq = '0;
    logic [7:0] rdData;
    logic rdValid;
    logic irqOrClockoutPin;
    logic secondIrqPinN;
    logic [7:0] expQ [$];
    logic [7:0] exp8;
    logic [7:0] val;
    logic last;
    int cnt;
    int numErrors = 0;
    int nTests = 0;
    logic [31:0] rnd = 32'h00013389;
    logic [127:0] rstImg = 128'h00000001010100000000000000001880;
    logic [55:0] tStart [5] = '{56'h59592307280204, 56'h59592303280205, 56'h59592305311299, 56'h59595101150610,
        56'h59592302311204};
    logic [55:0] tEnd [5] = '{56'h00000001290204, 56'h00000004010305, 56'h00000006018100, 56'h00007201150610,
        56'h00000003010105};
    logic [7:0] rateCtl [5] = '{8'h18, 8'h10, 8'h08, 8'h00, 8'h04};
    int rateExp [5] = '{64, 16, 8, 4, 0};

    always #2 clk = ~clk;

    bcc_xtal_model xtalModel (.run(xtalRun), .pin(xtalPin));

    bcc_clock_calendar #(.XTAL_DIV(16), .OSC_TIMEOUT_CYC(64)) DUT (
        .clk(clk), .rst(rst), .crystalInputPin(xtalPin), .hostReq(hostReq), .rdData(rdData),
        .rdValid(rdValid), .irqOrClockoutPin(irqOrClockoutPin), .secondIrqPinN(secondIrqPinN));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic fail_msg(input string m);
        numErrors++;
        $display("BAD %0t %s", $time, m);
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        nTests++;
        if (got !== exp) fail_msg("pin level");
    endtask

    task automatic cmp_count(input int got, input int exp);
        nTests++;
        if (got < exp - 1 || got > exp + 1) fail_msg("toggle count");
    endtask

    // Oldest expected byte is matched against each read result
    always @(negedge clk) begin
        if (rdValid === 1'b1) begin
            nTests++;
            exp8 = (expQ.size() > 0) ? expQ.pop_front() : 8'hXX;
            if (rdData !== exp8) begin
                numErrors++;
                $display("BAD %0t read %h expected %h", $time, rdData, exp8);
            end
        end
    end

    task automatic op(input logic p, input logic w, input logic r, input logic [7:0] d);
        @(negedge clk);
        hostReq = '{p, w, r, d};
        @(negedge clk);
        hostReq = '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, 1'b0, a);
        op(1'b0, 1'b1, 1'b0, d);
    endtask

    task automatic rdn(input logic [7:0] e);
        expQ.push_back(e);
        op(1'b0, 1'b0, 1'b1, 8'h00);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        op(1'b1, 1'b0, 1'b0, a);
        rdn(e);
    endtask

    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_msg("timeout");
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        op(1'b1, 1'b0, 1'b0, 8'h00);
        for (int i = 0; i < 17; i++) rdn(rstImg[127 - 8 * (i % 16) -: 8]);
        cmp_bit(secondIrqPinN, 1'b1);
        rnd = xorshift(rnd);
        val = 8'(rnd % 7) + 8'h01;
        wr(8'h03, val);
        rd(8'h03, val);
        wr(8'h0F, 8'h00);
        $display("test reset done");
        for (int k = 0; k < 5; k++) begin
            op(1'b1, 1'b0, 1'b0, 8'h00);
            for (int i = 0; i < 7; i++) op(1'b0, 1'b1, 1'b0, tStart[k][55 - 8 * i -: 8]);
            repeat (480) @(negedge clk);
            op(1'b1, 1'b0, 1'b0, 8'h00);
            for (int i = 0; i < 7; i++) rdn(tEnd[k][55 - 8 * i -: 8]);
        end
        $display("test calendar done");
        wr(8'h0E, 8'h98);
        wr(8'h00, 8'h00);
        repeat (480) @(negedge clk);
        rd(8'h00, 8'h00);
        wr(8'h0E, 8'h18);
        xtalRun = 1'b0;
        repeat (200) @(negedge clk);
        wr(8'h0F, 8'h00);
        rd(8'h0F, 8'h80);
        xtalRun = 1'b1;
        repeat (100) @(negedge clk);
        wr(8'h0F, 8'h00);
        rd(8'h0F, 8'h00);
        $display("test oscillator done");
        for (int i = 7; i < 11; i++) wr(8'(i), 8'h80);
        wr(8'h0E, 8'h19);
        wr(8'h0F, 8'h00);
        wr(8'h00, 8'h00);
        repeat (480) @(negedge clk);
        rd(8'h0F, 8'h01);
        cmp_bit(secondIrqPinN, 1'b0);
        wr(8'h0F, 8'hFF);
        rd(8'h0F, 8'h01);
        wr(8'h0F, 8'h02);
        rd(8'h0F, 8'h00);
        cmp_bit(secondIrqPinN, 1'b1);
        wr(8'h07, 8'h30);
        wr(8'h0B, 8'h01);
        wr(8'h0C, 8'h80);
        wr(8'h0D, 8'h80);
        wr(8'h0E, 8'h1E);
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h59);
        wr(8'h0F, 8'h00);
        repeat (480) @(negedge clk);
        rd(8'h0F, 8'h02);
        cmp_bit(irqOrClockoutPin, 1'b0);
        cmp_bit(secondIrqPinN, 1'b1);
        wr(8'h0A, 8'h43);
        wr(8'h0F, 8'h00);
        wr(8'h00, 8'h29);
        repeat (480) @(negedge clk);
        rd(8'h0F, 8'h01);
        wr(8'h0A, 8'h03);
        wr(8'h0F, 8'h00);
        wr(8'h00, 8'h29);
        repeat (480) @(negedge clk);
        rd(8'h0F, 8'h00);
        $display("test alarms done");
        for (int k = 0; k < 5; k++) begin
            wr(8'h0E, rateCtl[k]);
            repeat (4) @(negedge clk);
            cnt = 0;
            last = irqOrClockoutPin;
            repeat (768) begin
                @(negedge clk);
                if (irqOrClockoutPin !== last) cnt++;
                last = irqOrClockoutPin;
            end
            cmp_count(cnt, rateExp[k]);
        end
        $display("test clock output done");
        repeat (10) @(negedge clk);
        if (expQ.size() != 0) fail_msg("reads missing");
        report_and_stop();
    end
endmodule
